// ===== sim/irrx_ir_source.sv
`timescale 1ns/100ps
`default_nettype none
module irrx_ir_source (
  input  wire logic active,
  input  wire logic invert,
  output logic      ir_input
);
  // A negative phase source pulls the pin low while its pulse is active.
  assign ir_input = active ^ invert;
endmodule : irrx_ir_source
`default_nettype wire

// ===== sim/irrx_receiver_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module irrx_receiver_monitor (
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic       dec_guide_ok,
  input wire logic       dec_bit_valid,
  input wire logic       dec_error,
  input wire logic       dec_frame_end,
  input wire logic       start_pulse,
  input wire logic       data_phase,
  input wire logic       prescale_tick,
  input wire logic       irq,
  input wire logic       wake
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [2:0] wh;
  logic [2:0] eh;
  logic [2:0] sh;
  // Short histories of writes, decoder events and start pulses.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wh <= 3'h0;
      eh <= 3'h0;
      sh <= 3'h0;
    end else begin
      wh <= {wh[1:0], reg_write};
      eh <= {eh[1:0], dec_guide_ok | dec_bit_valid | dec_error | dec_frame_end};
      sh <= {sh[1:0], start_pulse};
    end
  end
  sequence s_one_cycle(sig);
    ##1 !sig;
  endsequence
  sequence s_cause;
    (|eh) || (|sh) || start_pulse;
  endsequence
  a_rdata_idle_zero: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside the answer cycle");
  a_start_one_cycle: assert property (start_pulse |-> s_one_cycle(start_pulse))
    else $error("start pulse longer than one cycle");
  a_presc_tick_pulse: assert property (prescale_tick |-> s_one_cycle(prescale_tick))
    else $error("prescaler tick on two cycles in a row");
  a_wake_needs_irq: assert property (wake |-> irq)
    else $error("wake without interrupt request");
  a_irq_rise_cause: assert property ($rose(irq) |-> (|(wh | eh)))
    else $error("interrupt rose without event or write");
  a_irq_fall_write: assert property ($fell(irq) |-> (|wh))
    else $error("interrupt fell without a register write");
  a_wake_fall_write: assert property ($fell(wake) |-> (|wh))
    else $error("wake fell without a register write");
  a_phase_has_cause: assert property ($rose(data_phase) |-> s_cause)
    else $error("data phase entered without guide or start");
endmodule : irrx_receiver_monitor
bind irrx_receiver irrx_receiver_monitor u_mon (
  .clock, .rst_n, .reg_write, .reg_read, .reg_rdata, .dec_guide_ok,
  .dec_bit_valid, .dec_error, .dec_frame_end, .start_pulse,
  .data_phase, .prescale_tick, .irq, .wake);
`default_nettype wire

// ===== sim/irrx_receiver_tb.sv
`timescale 1ns/100ps
`default_nettype none
module irrx_receiver_tb;
  import irrx_pkg::*;
  logic              clock;
  logic              rst_n;
  logic [ADDR_W-1:0] reg_addr;
  logic [7:0]        reg_wdata;
  logic              reg_write;
  logic              reg_read;
  logic [7:0]        reg_rdata;
  logic [3:0]        dv;
  logic              dbit;
  logic              act;
  logic              inv;
  logic              ir_input;
  logic              ir_level;
  logic              start_pulse;
  logic              irq;
  logic              wake;
  logic              hold;
  logic              sub;
  logic              sample_tick;
  logic              prescale_tick;
  int                err_total;
  int                n_compared;
  irrx_ir_source SRC (.active(act), .invert(inv), .ir_input(ir_input));
  irrx_receiver DUT (
    .clock, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .ir_input, .subclock(sub), .crystal_hold(hold),
    .dec_guide_ok(dv[0]), .dec_bit_valid(dv[1]), .dec_bit_value(dbit),
    .dec_error(dv[2]), .dec_frame_end(dv[3]), .ir_level, .start_pulse,
    .data_phase(), .sample_tick, .prescale_tick, .irq, .wake);
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask : rd
  task automatic ev(input int k, input logic v);
    @(posedge clock);
    dv   <= 4'(1 << k);
    dbit <= v;
    @(posedge clock);
    dv <= 4'h0;
  endtask : ev
  task automatic bits(input logic [7:0] b, input int n, input logic msb);
    for (int i = 0; i < n; i++) begin
      ev(1, msb ? b[n-1-i] : b[i]);
    end
  endtask : bits
  task automatic t_regs;
    rd(ADDR_EVENTS, 8'h00);
    rd(ADDR_COUNT_PRESC, 8'h00);
    wr(ADDR_SHIFT, 8'hFF);
    wr(ADDR_HOLDING, 8'hFF);
    wr(ADDR_COUNT_PRESC, 8'hFF);
    wr(16'hFE30, 8'hFF);
    rd(ADDR_SHIFT, 8'h00);
    rd(ADDR_COUNT_PRESC, 8'hF0);
    rd(16'hFE30, 8'h00);
    wr(ADDR_COUNT_PRESC, 8'h00);
  endtask : t_regs
  task automatic t_byte;
    wr(ADDR_EVENTS, 8'h55);
    wr(ADDR_CONTROL, 8'h87);
    ev(0, 1'b0);
    rd(ADDR_EVENTS, 8'hD5);
    bits(8'hA6, 8, 1'b0);
    rd(ADDR_EVENTS, 8'hDD);
    rd(ADDR_HOLDING, 8'hA6);
    rd(ADDR_COUNT_PRESC, 8'h00);
    rd(ADDR_SHIFT, 8'h00);
    chk({6'h00, wake, irq}, 8'h01);
    wr(ADDR_EVENTS, 8'h55);
    repeat (3) @(posedge clock);
    chk({7'h00, irq}, 8'h00);
  endtask : t_byte
  task automatic t_left;
    wr(ADDR_CONTROL, 8'h07);
    wr(ADDR_DIRECTION, 8'h80);
    wr(ADDR_EVENTS, 8'h00);
    wr(ADDR_CONTROL, 8'h87);
    ev(0, 1'b0);
    bits(8'h05, 3, 1'b1);
    ev(3, 1'b0);
    ev(1, 1'b1);
    rd(ADDR_EVENTS, 8'h82);
    rd(ADDR_COUNT_PRESC, 8'h0B);
    rd(ADDR_SHIFT, 8'h05);
    rd(ADDR_COUNT_PRESC, 8'h03);
    wr(ADDR_CONTROL, 8'h07);
    rd(ADDR_SHIFT, 8'h00);
    rd(ADDR_COUNT_PRESC, 8'h00);
  endtask : t_left
  task automatic t_fmts;
    for (int f = 0; f < 5; f++) begin
      wr(ADDR_EVENTS, 8'h00);
      wr(ADDR_CONTROL, {1'b1, 3'(f), 4'h7});
      ev(0, 1'b0);
      rd(ADDR_EVENTS, (f == 2 || f == 3) ? 8'h00 : 8'h80);
      wr(ADDR_CONTROL, 8'h07);
    end
    wr(ADDR_CONTROL, 8'hA7);
    ev(2, 1'b0);
    rd(ADDR_EVENTS, 8'hA0);
    wr(ADDR_CONTROL, 8'h07);
  endtask : t_fmts
  task automatic t_wake;
    wr(ADDR_EVENTS, 8'h01);
    wr(ADDR_CONTROL, 8'h86);
    ev(3, 1'b0);
    repeat (2) @(posedge clock);
    #1 chk({6'h00, wake, irq}, 8'h03);
    wr(ADDR_CONTROL, 8'h06);
    repeat (2) @(posedge clock);
    #1 chk({6'h00, wake, irq}, 8'h01);
    wr(ADDR_EVENTS, 8'h00);
  endtask : t_wake
  task automatic count_ticks(input int cycles, output int ns, output int np);
    ns = 0;
    np = 0;
    repeat (cycles) begin
      @(posedge clock);
      #1;
      ns += sample_tick;
      np += prescale_tick;
    end
  endtask : count_ticks
  task automatic t_tick;
    int ns;
    int np;
    wr(ADDR_CONTROL, 8'h80);
    count_ticks(40, ns, np);
    chk(8'(ns), 8'h0A);
    wr(ADDR_CONTROL, 8'h07);
    wr(ADDR_CONTROL, 8'hB7);
    count_ticks(40, ns, np);
    chk(8'(ns), 8'h28);
    chk(8'(np), 8'h14);
    hold <= 1'b1;
    count_ticks(20, ns, np);
    chk(8'(ns), 8'h00);
    wr(ADDR_CONTROL, 8'h07);
    wr(ADDR_CONTROL, 8'h86);
    ns = 0;
    for (int i = 0; i < 48; i++) begin
      @(posedge clock);
      sub <= i[2];
      #1 ns += sample_tick;
    end
    chk(8'(ns), 8'h05);
    hold <= 1'b0;
    sub  <= 1'b0;
    wr(ADDR_CONTROL, 8'h07);
  endtask : t_tick
  task automatic t_polar;
    int n;
    for (int i = 0; i < 2; i++) begin
      inv <= 1'(i);
      act <= 1'b1;
      repeat (5) @(posedge clock);
      wr(ADDR_CONTROL, {4'h8, 1'(i), 3'h7});
      #1;
      n = 0;
      while (start_pulse !== 1'b1 && n < 50) begin
        @(posedge clock);
        #1;
        n++;
      end
      chk({7'h00, start_pulse}, 8'h01);
      repeat (2) @(posedge clock);
      #1 chk({7'h00, ir_level}, 8'h01);
      act <= 1'b0;
      repeat (10) @(posedge clock);
      #1 chk({7'h00, ir_level}, 8'h00);
      wr(ADDR_CONTROL, 8'h07);
    end
  endtask : t_polar
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    rst_n = 1'b0;
    reg_addr = '0;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    dv = 4'h0;
    dbit = 1'b0;
    act = 1'b0;
    inv = 1'b0;
    hold = 1'b0;
    sub = 1'b0;
    err_total = 0;
    n_compared = 0;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    t_regs;
    t_byte;
    t_left;
    t_fmts;
    t_wake;
    t_tick;
    t_polar;
    print_verdict;
  end
  initial begin
    #100000;
    err_total++;
    print_verdict;
  end
endmodule : irrx_receiver_tb
`default_nettype wire

// ===== src/irrx_pkg.sv
`default_nettype none
package irrx_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam logic [15:0] ADDR_CONTROL      = 16'hFE27;
  localparam logic [15:0] ADDR_EVENTS       = 16'hFE28;
  localparam logic [15:0] ADDR_SHIFT        = 16'hFE29;
  localparam logic [15:0] ADDR_HOLDING      = 16'hFE2A;
  localparam logic [15:0] ADDR_COUNT_PRESC  = 16'hFE2B;
  localparam logic [15:0] ADDR_DIRECTION    = 16'hFE2F;
  localparam logic [7:0]  RESET_CONTROL     = 8'h00;
  localparam logic [7:0]  RESET_EVENTS      = 8'h00;
  localparam logic [7:0]  RESET_SHIFT       = 8'h00;
  localparam logic [3:0]  RESET_PRESC_SEL   = 4'h0;
  localparam logic        RESET_DIRECTION   = 1'b0;
  localparam int unsigned CTL_RUN_BIT       = 7;
  localparam int unsigned CTL_FMT_LSB       = 4;
  localparam int unsigned CTL_INV_BIT       = 3;
  localparam int unsigned CTL_CK_LSB        = 0;
  localparam int unsigned EV_GUIDE_FLAG     = 7;
  localparam int unsigned EV_GUIDE_EN       = 6;
  localparam int unsigned EV_ERROR_FLAG     = 5;
  localparam int unsigned EV_ERROR_EN       = 4;
  localparam int unsigned EV_FULL_FLAG      = 3;
  localparam int unsigned EV_FULL_EN        = 2;
  localparam int unsigned EV_END_FLAG       = 1;
  localparam int unsigned EV_END_EN         = 0;
  localparam int unsigned CP_GUIDE_LSB      = 6;
  localparam int unsigned CP_DATA_LSB       = 4;
  localparam int unsigned CP_HOLD_BIT       = 3;
  localparam int unsigned DIR_BIT           = 7;
  localparam logic [2:0]  CK_SUBCLOCK       = 3'h6;
  localparam logic [2:0]  CK_ONE_CYCLE      = 3'h7;
  localparam logic [7:0]  BASE_PERIOD       = 8'h04;
  localparam logic [5:0]  PRESC_BASE_LONG   = 6'h04;
  localparam logic [5:0]  PRESC_BASE_SHORT  = 6'h02;
  localparam logic [2:0]  FMT_A             = 3'h0;
  localparam logic [2:0]  FMT_B             = 3'h1;
  localparam logic [2:0]  FMT_C             = 3'h2;
  localparam logic [2:0]  FMT_D             = 3'h3;
  localparam logic [2:0]  FMT_E             = 3'h4;
  localparam logic [2:0]  BIT_COUNT_LAST    = 3'h7;
endpackage : irrx_pkg
`default_nettype wire

// ===== src/irrx_receiver.sv
// Function
// - Polarity bit one inverts the remote input.
// - Active level at switch-on acts as start.
// - Clock select picks divided, subclock or single cycle.
// - During crystal hold only subclock sampling runs.
// - Wake allowed only if started on subclock.
// - Guide flag set only in formats 0,1,4.
// - Event flags cleared only by software writes.
// - Flag and enable raise interrupt and wake.
// - Data error flag set on checking error.
// - Full flag set on transfer to holding.
// - Frame end flag set on end condition.
// - Shift loads LSB or MSB first.
// - Shift cleared on stop, guide, edge, transfer.
// - Leftover bits stay in shift register.
// - Holding register undefined at reset, loaded per byte.
// - Three-bit counter counts decoded bits.
// - Bit counter cleared on stop, guide, edge.
// - Low nibble of count register read-only.
// - Prescale selects give counts per format.
// - Run bit starts and stops the receiver.
// - Format codes 0 to 4 select formats.
// - Hold at frame end until shift read.
// - Direction bit zero LSB first, one MSB.
`timescale 1ns/100ps
`default_nettype none
module irrx_receiver
  import irrx_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  output logic      [7:0]        reg_rdata,
  input  wire logic              ir_input,
  input  wire logic              subclock,
  input  wire logic              crystal_hold,
  input  wire logic              dec_guide_ok,
  input  wire logic              dec_bit_valid,
  input  wire logic              dec_bit_value,
  input  wire logic              dec_error,
  input  wire logic              dec_frame_end,
  output logic                   ir_level,
  output logic                   start_pulse,
  output logic                   data_phase,
  output logic                   sample_tick,
  output logic                   prescale_tick,
  output logic                   irq,
  output logic                   wake
);

  logic [7:0] control;
  logic [7:0] events;
  logic [7:0] rx_shift_reg;
  logic [7:0] rx_holding_reg;
  logic [2:0] rx_bit_counter;
  logic       frame_hold_flag;
  logic [3:0] prescale_select;
  logic       shift_direction_select;
  logic [2:0] in_sync;
  logic       in_filt;
  logic [2:0] sub_sync;
  logic       sub_filt;
  logic       run_d;
  logic       edge_armed;
  logic       started_on_subclock;
  logic [7:0] sample_count;
  logic [5:0] presc_count;

  logic       run;
  logic [2:0] fmt;
  logic [2:0] clk_sel;
  logic       guide_fmt;
  logic       active_now;
  logic       sub_rise;
  logic       live;
  logic       take_bit;
  logic       byte_done;
  logic       start_now;
  logic       clear_frame;
  logic       next_sample_tick;
  logic       next_prescale_tick;
  logic [7:0] period;
  logic [5:0] presc_limit;
  logic [7:0] next_shift;
  logic [7:0] flag_set;
  logic       sel_wr_control;
  logic       sel_wr_events;
  logic       sel_wr_cp;
  logic       sel_wr_dir;

  function automatic logic [7:0] read_mux(input logic [ADDR_W-1:0] a);
    case (a)
      ADDR_CONTROL:     read_mux = control;
      ADDR_EVENTS:      read_mux = events;
      ADDR_SHIFT:       read_mux = rx_shift_reg;
      ADDR_HOLDING:     read_mux = rx_holding_reg;
      ADDR_COUNT_PRESC: read_mux = {prescale_select, frame_hold_flag,
                                    rx_bit_counter};
      ADDR_DIRECTION:   read_mux = {shift_direction_select, 7'h00};
      default:          read_mux = 8'h00;
    endcase
  endfunction : read_mux

  function automatic logic is_subclock(input logic [2:0] sel);
    is_subclock = (sel == CK_SUBCLOCK);
  endfunction : is_subclock

  function automatic logic [5:0] presc_count_for(input logic [2:0] f,
                                                 input logic [1:0] s);
    if (f == FMT_D || f == FMT_E) begin
      presc_count_for = PRESC_BASE_SHORT << s;
    end else begin
      presc_count_for = PRESC_BASE_LONG << s;
    end
  endfunction : presc_count_for

  assign run            = control[CTL_RUN_BIT];
  assign fmt            = control[CTL_FMT_LSB +: 3];
  assign clk_sel        = control[CTL_CK_LSB +: 3];
  assign guide_fmt      = (fmt == FMT_A) || (fmt == FMT_B) || (fmt == FMT_E);
  assign active_now     = in_filt ^ control[CTL_INV_BIT];
  assign sub_rise       = (sub_sync[2] == sub_sync[1]) && sub_sync[1]
                          && !sub_filt;
  assign live           = run && !frame_hold_flag;
  assign take_bit       = live && dec_bit_valid;
  assign byte_done      = take_bit && (rx_bit_counter == BIT_COUNT_LAST);
  // A start is the switch-on level or a later rising active edge.
  assign start_now      = live && active_now && (!run_d || !ir_level);
  // In formats 2 and 3 the switch-on start also counts as the first edge of a frame.
  assign clear_frame    = (live && dec_guide_ok && guide_fmt)
                          || (start_now && (edge_armed || !run_d)
                              && !guide_fmt);
  assign sel_wr_control = reg_write && (reg_addr == ADDR_CONTROL);
  assign sel_wr_events  = reg_write && (reg_addr == ADDR_EVENTS);
  assign sel_wr_cp      = reg_write && (reg_addr == ADDR_COUNT_PRESC);
  assign sel_wr_dir     = reg_write && (reg_addr == ADDR_DIRECTION);

  always_comb begin
    case (control[CTL_CK_LSB +: 3])
      CK_SUBCLOCK:  period = 8'h00;
      CK_ONE_CYCLE: period = 8'h01;
      default:      period = BASE_PERIOD << control[CTL_CK_LSB +: 3];
    endcase
    if (!run) begin
      next_sample_tick = 1'b0;
    end else if (is_subclock(clk_sel)) begin
      next_sample_tick = sub_rise;
    end else begin
      next_sample_tick = !crystal_hold
                         && (sample_count == period - 8'h01);
    end
  end

  always_comb begin
    presc_limit = presc_count_for(fmt, data_phase ? prescale_select[1:0]
                                                  : prescale_select[3:2]);
    next_prescale_tick = next_sample_tick
                         && (presc_count == presc_limit - 6'h01);
  end

  always_comb begin
    if (shift_direction_select) begin
      next_shift = {rx_shift_reg[6:0], dec_bit_value};
    end else begin
      next_shift = {dec_bit_value, rx_shift_reg[7:1]};
    end
  end

  always_comb begin
    flag_set = 8'h00;
    flag_set[EV_GUIDE_FLAG] = live && dec_guide_ok && guide_fmt;
    flag_set[EV_ERROR_FLAG] = live && dec_error;
    flag_set[EV_FULL_FLAG]  = byte_done;
    flag_set[EV_END_FLAG]   = live && dec_frame_end;
  end

  // Three stages; a change counts once stages two and three agree.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      in_sync  <= 3'h0;
      in_filt  <= 1'b0;
      sub_sync <= 3'h0;
      sub_filt <= 1'b0;
    end else begin
      in_sync  <= {in_sync[1:0], ir_input};
      sub_sync <= {sub_sync[1:0], subclock};
      if (in_sync[2] == in_sync[1]) begin
        in_filt <= in_sync[2];
      end
      if (sub_sync[2] == sub_sync[1]) begin
        sub_filt <= sub_sync[2];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      control                <= RESET_CONTROL;
      prescale_select        <= RESET_PRESC_SEL;
      shift_direction_select <= RESET_DIRECTION;
    end else begin
      if (sel_wr_control) begin
        control <= reg_wdata;
      end
      if (sel_wr_cp) begin
        prescale_select <= reg_wdata[7:4];
      end
      if (sel_wr_dir) begin
        shift_direction_select <= reg_wdata[DIR_BIT];
      end
    end
  end

  // A hardware set wins over a software clear in the same cycle.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      events <= RESET_EVENTS;
    end else if (sel_wr_events) begin
      events <= reg_wdata | flag_set;
    end else begin
      events <= events | flag_set;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      // Each flag pairs with the enable bit just below it.
      irq  <= 1'b0;
      wake <= 1'b0;
      started_on_subclock <= 1'b0;
    end else begin
      irq  <= |(events[7:0] & {events[6:0], 1'b0} &
                8'b1010_1010);
      wake <= started_on_subclock && run
              && |(events & {events[6:0], 1'b0} & 8'hAA);
      if (run && !run_d) begin
        started_on_subclock <= is_subclock(clk_sel);
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sample_count  <= 8'h00;
      presc_count   <= 6'h00;
      sample_tick   <= 1'b0;
      prescale_tick <= 1'b0;
    end else begin
      sample_tick   <= next_sample_tick;
      prescale_tick <= next_prescale_tick;
      if (!run || next_sample_tick
          || is_subclock(clk_sel)) begin
        sample_count <= 8'h00;
      end else if (!crystal_hold) begin
        sample_count <= sample_count + 8'h01;
      end
      if (!run || next_prescale_tick || clear_frame) begin
        presc_count <= 6'h00;
      end else if (next_sample_tick) begin
        presc_count <= presc_count + 6'h01;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      run_d           <= 1'b0;
      ir_level        <= 1'b0;
      start_pulse     <= 1'b0;
      edge_armed      <= 1'b0;
      data_phase      <= 1'b0;
      frame_hold_flag <= 1'b0;
    end else begin
      run_d       <= run;
      ir_level    <= run && active_now;
      start_pulse <= start_now;
      if (!run) begin
        frame_hold_flag <= 1'b0;
        edge_armed      <= 1'b0;
        data_phase      <= 1'b0;
      end else if (live && dec_frame_end) begin
        frame_hold_flag <= 1'b1;
        data_phase      <= 1'b0;
      end else if (reg_read && reg_addr == ADDR_SHIFT) begin
        frame_hold_flag <= 1'b0;
        edge_armed      <= 1'b1;
      end else begin
        if (!run_d) begin
          edge_armed <= 1'b1;
        end else if (clear_frame) begin
          edge_armed <= 1'b0;
        end
        if (clear_frame) begin
          data_phase <= 1'b1;
        end else if (live && dec_error) begin
          data_phase <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_shift_reg   <= RESET_SHIFT;
      rx_bit_counter <= 3'h0;
    end else if (!run || clear_frame) begin
      rx_shift_reg   <= RESET_SHIFT;
      rx_bit_counter <= 3'h0;
    end else if (byte_done) begin
      rx_shift_reg   <= RESET_SHIFT;
      rx_bit_counter <= 3'h0;
    end else if (take_bit) begin
      rx_shift_reg   <= next_shift;
      rx_bit_counter <= rx_bit_counter + 3'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (byte_done) begin
      rx_holding_reg <= next_shift;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      reg_rdata <= read_mux(reg_addr);
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule : irrx_receiver
`default_nettype wire
